// File: design/tws_pkg.sv
package tws_pkg;
	localparam int PTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam logic [13:0] TABLE_WRITE_PREFIX = 14'h0003;
	localparam logic [6:0] TEST_SKIP_PREFIX = 7'h33;
	localparam logic [7:0] XOR_LITERAL_UPPER = 8'h0A;
	localparam logic [1:0] PTR_KEEP = 2'h0;
	localparam logic [1:0] PTR_POST_INC = 2'h1;
	localparam logic [1:0] PTR_POST_DEC = 2'h2;
	localparam logic [1:0] PTR_PRE_INC = 2'h3;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_BANK = 4'h0;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] SFR_BANK = 4'hF;
	localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
	localparam logic [7:0] W_RESET = 8'h00;
endpackage

// File: design/tws_hold_mem.sv
module tws_hold_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem_ff [DEPTH];
	logic [7:0] rd_data_ff;
	// contents only; committing to flash happens elsewhere
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= mem_ff[rd_addr];
		end
	end
	assign rd_data = rd_data_ff;
endmodule

// File: design/tws_exec.sv
module tws_exec (
	clk,
	rst,
	instr_valid,
	instr,
	next_two_word,
	ext_set_en,
	bank_select_reg,
	file_rdata,
	table_latch,
	hold_rd_sel,
	file_raddr,
	file_idx_mode,
	stall,
	flush_next,
	w_reg,
	neg_flag,
	zero_flag,
	table_pointer,
	hold_rd_data
);
	input  wire logic                       clk;
	input  wire logic                       rst;
	input  wire logic                       instr_valid;
	input  wire logic [15:0]                instr;
	input  wire logic                       next_two_word;
	input  wire logic                       ext_set_en;
	input  wire logic [3:0]                 bank_select_reg;
	input  wire logic [7:0]                 file_rdata;
	input  wire logic [7:0]                 table_latch;
	input  wire logic [2:0]                 hold_rd_sel;
	output logic      [11:0]                file_raddr;
	output logic                            file_idx_mode;
	output logic                            stall;
	output logic                            flush_next;
	output logic      [7:0]                 w_reg;
	output logic                            neg_flag;
	output logic                            zero_flag;
	output logic      [tws_pkg::PTR_W-1:0]  table_pointer;
	output logic      [7:0]                 hold_rd_data;

	typedef enum logic [1:0] {EX_RUN, EX_TBL2, EX_SKIP1, EX_SKIP2} tws_state_t;

	tws_state_t                st_ff, nxt_st;
	logic [tws_pkg::PTR_W-1:0] ptr_ff, nxt_ptr;
	logic [7:0]                w_ff, nxt_w;
	logic                      n_ff, nxt_n;
	logic                      z_ff, nxt_z;
	logic [1:0]                mode_ff, nxt_mode;
	logic                      skip_two_ff, nxt_skip_two;
	logic                      hold_we;
	logic [tws_pkg::HOLD_SEL_W-1:0] hold_wa;
	logic                      taken;
	logic                      is_tbl_write, is_tst, is_xor;
	logic                      tst_hit;
	logic                      file_a;
	logic [7:0]                file_f;
	logic [7:0]                xor_res;

	// a word is taken only in the run state; the extra cycles ignore the fetch side
	assign taken = instr_valid && (st_ff == EX_RUN);
	assign file_f = instr[7:0];
	assign file_a = instr[8];

	assign is_tbl_write = taken && (instr[15:2] == tws_pkg::TABLE_WRITE_PREFIX);
	assign is_tst = taken && (instr[15:9] == tws_pkg::TEST_SKIP_PREFIX);
	assign is_xor = taken && (instr[15:8] == tws_pkg::XOR_LITERAL_UPPER);
	// skip only on a zero file byte
	assign tst_hit = is_tst && (file_rdata == 8'h00);
	assign xor_res = w_ff ^ instr[7:0];

	always_comb begin
		file_idx_mode = !file_a && ext_set_en && (file_f <= tws_pkg::IDX_LIMIT);
		if (file_a) begin
			file_raddr = {bank_select_reg, file_f};
		end else if (file_f < tws_pkg::ACCESS_SPLIT) begin
			file_raddr = {tws_pkg::ACCESS_BANK, file_f};
		end else begin
			// access addresses from 0x60 upward land in the special register bank
			file_raddr = {tws_pkg::SFR_BANK, file_f};
		end
	end

	// sequencer: which extra cycles follow a decode
	always_comb begin
		nxt_st = st_ff;
		nxt_mode = mode_ff;
		nxt_skip_two = skip_two_ff;
		unique case (st_ff)
			EX_RUN: begin
				if (is_tbl_write) begin
					// mode is kept for the post step in the second cycle
					nxt_mode = instr[1:0];
					nxt_st = EX_TBL2;
				end else if (tst_hit) begin
					nxt_skip_two = next_two_word;
					nxt_st = EX_SKIP1;
				end
			end
			EX_TBL2: begin
				// latch byte moves at the end of this cycle
				nxt_st = EX_RUN;
			end
			EX_SKIP1: begin
				// a two-word victim costs one more cycle
				nxt_st = skip_two_ff ? EX_SKIP2 : EX_RUN;
			end
			EX_SKIP2: begin
				// second nop cycle for the trailing word
				nxt_st = EX_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= EX_RUN;
			mode_ff <= tws_pkg::PTR_KEEP;
			skip_two_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			mode_ff <= nxt_mode;
			skip_two_ff <= nxt_skip_two;
		end
	end

	// fetch-side handshake is combinational so the discard hits the word already fetched
	always_comb begin
		// no new word is taken in an extra cycle
		stall = (st_ff != EX_RUN);
		flush_next = 1'b0;
		if (st_ff == EX_RUN) begin
			flush_next = tst_hit;
		end else if (st_ff == EX_SKIP1) begin
			// second word of a two-word victim goes too
			flush_next = skip_two_ff;
		end
		hold_wa = ptr_ff[tws_pkg::HOLD_SEL_W-1:0];
		// strobe reaches the holding store only
		hold_we = (st_ff == EX_TBL2);
	end

	// pointer: a pre-increment lands at decode, a post step at the same edge the byte moves to the old address
	always_comb begin
		nxt_ptr = ptr_ff;
		// full-width stepping, wraps at the top of the space
		if (is_tbl_write && (instr[1:0] == tws_pkg::PTR_PRE_INC)) begin
			nxt_ptr = ptr_ff + 21'h000001;
		end else if (st_ff == EX_TBL2) begin
			// a pre-increment already stepped at decode
			unique case (mode_ff)
				tws_pkg::PTR_POST_INC: nxt_ptr = ptr_ff + 21'h000001;
				tws_pkg::PTR_POST_DEC: nxt_ptr = ptr_ff - 21'h000001;
				default: nxt_ptr = ptr_ff;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= tws_pkg::PTR_RESET;
		end else begin
			ptr_ff <= nxt_ptr;
		end
	end

	// working register and flags: only the xor literal touches them
	always_comb begin
		nxt_w = w_ff;
		nxt_n = n_ff;
		nxt_z = z_ff;
		if (is_xor) begin
			nxt_w = xor_res;
			nxt_n = xor_res[7];
			nxt_z = (xor_res == 8'h00);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_ff <= tws_pkg::W_RESET;
			n_ff <= 1'b0;
			z_ff <= 1'b0;
		end else begin
			w_ff <= nxt_w;
			n_ff <= nxt_n;
			z_ff <= nxt_z;
		end
	end

	tws_hold_mem #(
		.DEPTH(tws_pkg::HOLD_N),
		.AW   (tws_pkg::HOLD_SEL_W)
	) u_hold (
		.clk    (clk),
		.rst    (rst),
		.wr_en  (hold_we),
		.wr_addr(hold_wa),
		.wr_data(table_latch),
		.rd_addr(hold_rd_sel),
		.rd_data(hold_rd_data)
	);

	// bit zero is byte lane of the word
	assign table_pointer = ptr_ff;
	assign w_reg = w_ff;
	assign neg_flag = n_ff;
	assign zero_flag = z_ff;
endmodule

// File: verif/tws_exec_asserts.sv
module tws_exec_asserts (
	input logic                      clk,
	input logic                      rst,
	input logic                      instr_valid,
	input logic [15:0]               instr,
	input logic                      next_two_word,
	input logic [3:0]                bank_select_reg,
	input logic [7:0]                file_rdata,
	input logic [11:0]               file_raddr,
	input logic                      stall,
	input logic                      flush_next,
	input logic [7:0]                w_reg,
	input logic                      neg_flag,
	input logic                      zero_flag,
	input logic [tws_pkg::PTR_W-1:0] table_pointer
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire go = instr_valid && !stall;
	wire xo = go && instr[15:8] == 8'h0A;
	wire tw = go && instr[15:2] == 14'h0003;
	wire ts = go && instr[15:9] == 7'h33;
	wire sk = ts && file_rdata == 8'h00;
	a_xor_result: assert property (xo |=> w_reg == ($past(w_reg) ^ $past(instr[7:0])))
		else $error("xor result");
	a_xor_flags: assert property (
		xo |=> zero_flag == (w_reg == 8'h00) && neg_flag == w_reg[7])
		else $error("xor flags");
	a_flags_kept: assert property (tw || ts |=> $stable({neg_flag, zero_flag}))
		else $error("flags moved");
	a_skip_flush: assert property (ts |-> flush_next == (file_rdata == 8'h00))
		else $error("skip flush");
	a_skip_long: assert property (sk && next_two_word |=> stall [*2] ##1 !stall)
		else $error("skip length");
	a_skip_short: assert property (sk && !next_two_word |=> stall ##1 !stall)
		else $error("skip short");
	a_bank_pick: assert property (
		ts && instr[8] |-> file_raddr == {bank_select_reg, instr[7:0]})
		else $error("bank select");
	a_pre_inc: assert property (
		tw && instr[1:0] == 2'h3 |=> table_pointer == $past(table_pointer) + 21'h1)
		else $error("pre increment");
	a_write_stall: assert property (tw |=> stall ##1 !stall)
		else $error("write stall");
endmodule
bind tws_exec tws_exec_asserts chk (.*);

// File: verif/tws_file_model.sv
module tws_file_model (
	input logic [11:0] file_raddr,
	output logic [7:0] file_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// a quarter of addresses read zero so skips are frequent but not constant
	assign file_rdata = (file_raddr[1:0] == 2'h0) ? 8'h00 : {file_raddr[11:6], file_raddr[1:0]};
endmodule

// File: verif/tb_table_write_skip_xor_exec.sv
`define C(a, b) begin n_checks++; if ((a) !== (b)) begin \
	failures++; $display("unexpected %0t mismatch", $time); end end
module tb_table_write_skip_xor_exec;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, instr_valid = 0, next_two_word = 0, ext_set_en = 0;
	logic        stall, neg_flag, zero_flag, flush_next, file_idx_mode, n = 0, z = 0;
	logic [15:0] instr = 0;
	logic [7:0]  file_rdata, w_reg, hold_rd_data, e, table_latch = 0, w = 0;
	logic [7:0]  hold [8];
	logic [3:0]  bank_select_reg = 0;
	logic [2:0]  hold_rd_sel = 0;
	logic [11:0] file_raddr, ea = 1;
	logic [20:0] table_pointer, ptr = 0;
	logic [31:0] rs = 32'h403E, r;
	int          failures = 0, n_checks = 0, stc = 0, nn = -1;
	tws_exec uut (.*);
	tws_file_model fm (.*);
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		forever #50 clk = ~clk;
	end
	initial begin
		#400000;
		failures++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 0;
		repeat (3000) begin
			@(posedge clk);
			// holding memory is not reset, so unwritten entries stay unknown on both sides
			e = hold[hold_rd_sel];
			if (stc > 0) begin
				stc--;
				if (nn >= 0) begin
					hold[ptr[2:0]] = table_latch;
					ptr = ptr + ((nn == 1) ? 21'h1 : (nn == 2) ? 21'h1FFFFF : 21'h0);
					nn = -1;
				end
			end else if (instr_valid) begin
				if (instr[15:8] == 8'h0A) begin
					w = w ^ instr[7:0];
					n = w[7];
					z = (w == 8'h00);
				end
				if (instr[15:2] == 14'h0003) begin
					nn = instr[1:0];
					stc = 1;
					if (nn == 3)
						ptr = ptr + 21'h1;
				end
				if (instr[15:9] == 7'h33 && ea[1:0] == 2'h0)
					stc = next_two_word ? 2 : 1;
			end
			#1;
			`C(w_reg, w)
			`C({neg_flag, zero_flag}, {n, z})
			`C(table_pointer, ptr)
			`C(hold_rd_data, e)
			`C(stall, stc != 0)
			`C(table_pointer[0], ptr[0])
			r = rnd();
			case (r[17:16])
				2'h0: instr = {8'h0A, r[7:0]};
				2'h1: instr = {14'h0003, r[1:0]};
				2'h2: instr = {7'h33, r[8:0]};
				default: instr = {4'hF, r[11:0]};
			endcase
			instr_valid = r[18] | r[19];
			next_two_word = r[20];
			ext_set_en = r[21];
			bank_select_reg = r[25:22];
			if (stc == 0)
				table_latch = r[31:24];
			// readback avoids the entry being written at the same edge
			hold_rd_sel = (nn >= 0) ? ptr[2:0] + 3'h1 : r[28:26];
			ea = {instr[8] ? bank_select_reg : (instr[7:0] < 8'h60) ? 4'h0 : 4'hF, instr[7:0]};
			#1;
			if (stc == 0 && instr_valid && instr[15:9] == 7'h33) begin
				`C(file_raddr, ea)
				`C(file_idx_mode, !instr[8] && ext_set_en && instr[7:0] <= 8'h5F)
				`C(flush_next, ea[1:0] == 2'h0)
			end else begin
				`C(flush_next, stc == 2)
			end
		end
		final_report();
	end
endmodule
